// >>> mpio_map.vh
`ifndef MPIO_MAP_VH
`define MPIO_MAP_VH

// ****************************************
// register byte offsets
// ****************************************
`define MPIO_DATA_BASE   8'h00
`define MPIO_DIR_BASE    8'h40
`define MPIO_PULLUP      8'h80
`define MPIO_P1_PULLUP   8'h84
`define MPIO_DRIVE       8'h88
`define MPIO_ANALOG      8'h8C
`define MPIO_PAIR        8'h90
`define MPIO_EDGE        8'h94
`define MPIO_IRQ_STAT    8'h98
`define MPIO_IRQ_MASK    8'h9C
`define MPIO_ALT         8'hA0
`define MPIO_BITOP       8'hA4

// ****************************************
// port slots, four pins each
// ****************************************
`define MPIO_NPORTS      4'h9
`define MPIO_P_INPUT     4'h1
`define MPIO_P_ANALOG    4'h2
`define MPIO_P_HCA       4'h4
`define MPIO_P_HCB       4'h5
`define MPIO_P_SHORT     4'h8

// ****************************************
// field positions
// ****************************************
`define MPIO_EV_EXT_A    0
`define MPIO_EV_EXT_B    1
`define MPIO_EV_QRISE    2
`define MPIO_EV_BOTH     3
`define MPIO_EV_KEY      4
`define MPIO_ALT_BUZ_EN  0
`define MPIO_ALT_CLO_EN  3
`define MPIO_ALT_P33_EN  4
`define MPIO_ALT_P33_SRC 5
`define MPIO_ALT_T0O_EN  6
`define MPIO_ALT_AN4     7
`define MPIO_ALT_AN5     8

// ****************************************
// reset values
// ****************************************
`define MPIO_ANALOG_RST  4'hF
`define MPIO_DRIVE_RST   2'h0
`define MPIO_EDGE_RST    2'h0

// ****************************************
// timing
// ****************************************
`define MPIO_CLK_NS      100
`define MPIO_FILT_NS     400
`define MPIO_FILT_CYC    ((`MPIO_FILT_NS + `MPIO_CLK_NS - 1) / `MPIO_CLK_NS)
`define MPIO_MCLK_HZ     25'h0989680
`define MPIO_WT_HZ       25'h0008000

`endif

// >>> mpio_top.v
`include "mpio_map.vh"

module mpio_top (
	input  wire        mclk,
	input  wire        rst,
	input  wire [7:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire        avs_waitrequest,
	output wire        irq,
	input  wire [35:0] pad_in,
	output wire [35:0] pad_out,
	output wire [35:0] pad_oe_n,
	output wire [35:0] pad_pullup,
	input  wire        system_clock_out,
	input  wire        pwm_out,
	input  wire        timer1_clock_out,
	input  wire        timer0_clock_out,
	output wire        timer1_ext_clock_in,
	output wire        timer0_ext_clock_in,
	output wire [5:0]  analog_inputs
);

	localparam integer FILT_N    = `MPIO_FILT_CYC - 1;
	localparam [2:0]   FILT_LAST = FILT_N[2:0];

	// ****************************************
	// decode helpers
	// ****************************************
	function port_hit;
		input [7:0] a;
		input [7:0] base;
		begin
			port_hit = (a[7:6] == base[7:6]) && (a[5:2] < `MPIO_NPORTS) && (a[1:0] == 2'h0);
		end
	endfunction

	function wr_ok;
		input [3:0] p;
		begin
			wr_ok = (p < `MPIO_NPORTS) && (p != `MPIO_P_INPUT);
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg [35:0] data_r;
	reg [35:0] dir_r;
	reg [8:0]  pu_r;
	reg [2:0]  p1pu_r;
	reg [1:0]  od_r;
	reg [3:0]  ana_r;
	reg [1:0]  edge_r;
	reg [4:0]  stat_r;
	reg [4:0]  mask_r;
	reg [8:0]  alt_r;

	// ****************************************
	// bus and pin-side state
	// ****************************************
	reg        wait_r;
	reg [31:0] rdata_r;
	reg        irq_r;
	reg [35:0] meta_r;
	reg [35:0] sync_r;
	reg [8:0]  filt_r;
	reg [8:0]  prev_r;
	reg [26:0] fcnt_r;
	reg [1:0]  settle_r;
	reg [24:0] wacc_r;
	reg [3:0]  wcnt_r;
	reg        buz_r;
	reg [35:0] pout_r;
	reg [35:0] poe_n_r;
	reg [35:0] ppu_r;
	reg        t1in_r;

	// ****************************************
	// request qualifiers
	// ****************************************
	// access completes on the edge where wait is low
	wire        req  = avs_read | avs_write;
	wire        acc  = req & ~wait_r;
	wire        wen  = acc & avs_write & avs_byteenable[0];
	wire [3:0]  pidx = avs_address[5:2];
	wire [5:0]  pbit = {pidx[3:0], 2'b00};
	wire [35:0] view = (dir_r & data_r) | (~dir_r & sync_r);
	wire [3:0]  bop_p = avs_writedata[3:0];
	wire [5:0]  bop_i = {bop_p, avs_writedata[5:4]};

	// ****************************************
	// avalon slave handshake
	// ****************************************
	reg [31:0] rd_nxt;
	always @* begin
		rd_nxt = 32'h00000000;
		if (port_hit(avs_address, `MPIO_DATA_BASE))
			rd_nxt[3:0] = view[pbit +: 4];
		else if (port_hit(avs_address, `MPIO_DIR_BASE))
			rd_nxt[3:0] = dir_r[pbit +: 4];
		else begin
			case (avs_address)
			`MPIO_PULLUP:    rd_nxt[8:0] = pu_r;
			`MPIO_P1_PULLUP: rd_nxt[2:0] = p1pu_r;
			`MPIO_DRIVE:     rd_nxt[1:0] = od_r;
			`MPIO_ANALOG:    rd_nxt[3:0] = ana_r;
			`MPIO_PAIR:      rd_nxt[7:0] = {view[23:20], view[19:16]};
			`MPIO_EDGE:      rd_nxt[1:0] = edge_r;
			`MPIO_IRQ_STAT:  rd_nxt[4:0] = stat_r;
			`MPIO_IRQ_MASK:  rd_nxt[4:0] = mask_r;
			`MPIO_ALT:       rd_nxt[8:0] = alt_r;
			default:         rd_nxt = 32'h00000000;
			endcase
		end
	end

	always @(posedge mclk) begin
		if (rst) begin
			wait_r  <= 1'b1;
			rdata_r <= 32'h00000000;
		end else if (req && wait_r) begin
			wait_r  <= 1'b0;
			rdata_r <= avs_read ? rd_nxt : 32'h00000000;
		end else begin
			wait_r  <= 1'b1;
		end
	end

	// ****************************************
	// register writes
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			data_r <= 36'h000000000;
			dir_r  <= 36'h000000000;
			pu_r   <= 9'h000;
			p1pu_r <= 3'h0;
			od_r   <= `MPIO_DRIVE_RST;
			ana_r  <= `MPIO_ANALOG_RST;
			edge_r <= `MPIO_EDGE_RST;
			mask_r <= 5'h00;
			alt_r  <= 9'h000;
		end else if (wen) begin
			if (port_hit(avs_address, `MPIO_DATA_BASE) && wr_ok(pidx))
				data_r[pbit +: 4] <= avs_writedata[3:0];
			if (port_hit(avs_address, `MPIO_DIR_BASE) && wr_ok(pidx))
				dir_r[pbit +: 4] <= (pidx == `MPIO_P_SHORT) ?
					{1'b0, avs_writedata[2:0]} : avs_writedata[3:0];
			case (avs_address)
			`MPIO_PULLUP:    pu_r <= avs_writedata[8:0] & 9'h1FD;
			`MPIO_P1_PULLUP: p1pu_r <= avs_writedata[2:0];
			`MPIO_DRIVE:     od_r <= avs_writedata[1:0];
			`MPIO_ANALOG:    ana_r <= avs_writedata[3:0];
			`MPIO_PAIR: begin
				data_r[19:16] <= avs_writedata[3:0];
				data_r[23:20] <= avs_writedata[7:4];
			end
			`MPIO_EDGE:      edge_r <= avs_writedata[1:0];
			`MPIO_IRQ_MASK:  mask_r <= avs_writedata[4:0];
			`MPIO_ALT: begin
				alt_r[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1])
					alt_r[8] <= avs_writedata[8];
			end
			`MPIO_BITOP: begin
				if (wr_ok(bop_p))
					data_r[bop_i] <= avs_writedata[6];
			end
			default: begin
			end
			endcase
		end
	end

	// ****************************************
	// pin synchroniser and noise filter
	// ****************************************
	wire [8:0] fsrc = {sync_r[32], sync_r[27:24], sync_r[7:4]};

	always @(posedge mclk) begin
		if (rst) begin
			meta_r   <= 36'h000000000;
			sync_r   <= 36'h000000000;
			settle_r <= 2'h3;
		end else begin
			meta_r <= pad_in;
			sync_r <= meta_r;
			if (settle_r != 2'h0)
				settle_r <= settle_r - 2'h1;
		end
	end

	genvar f;
	generate
		for (f = 0; f < 9; f = f + 1) begin : g_filt
			always @(posedge mclk) begin
				if (rst) begin
					filt_r[f]         <= 1'b0;
					prev_r[f]         <= 1'b0;
					fcnt_r[3*f +: 3]  <= 3'h0;
				end else begin
					prev_r[f] <= filt_r[f];
					if (settle_r != 2'h0) begin
						// load both stages so no false edge follows reset
						prev_r[f]        <= fsrc[f];
						filt_r[f]        <= fsrc[f];
						fcnt_r[3*f +: 3] <= 3'h0;
					end else if (fsrc[f] == filt_r[f]) begin
						fcnt_r[3*f +: 3] <= 3'h0;
					end else if (fcnt_r[3*f +: 3] == FILT_LAST) begin
						filt_r[f]        <= fsrc[f];
						fcnt_r[3*f +: 3] <= 3'h0;
					end else begin
						fcnt_r[3*f +: 3] <= fcnt_r[3*f +: 3] + 3'h1;
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// edge events and interrupt
	// ****************************************
	wire [3:0] rise = filt_r[3:0] & ~prev_r[3:0];
	wire [3:0] fall = ~filt_r[3:0] & prev_r[3:0];
	wire       armed = (settle_r == 2'h0);
	reg  [4:0] ev;
	reg  [4:0] stat_nxt;

	always @* begin
		ev = 5'h00;
		ev[`MPIO_EV_EXT_A] = edge_r[0] ? rise[0] : fall[0];
		ev[`MPIO_EV_EXT_B] = edge_r[1] ? rise[1] : fall[1];
		ev[`MPIO_EV_QRISE] = rise[2];
		ev[`MPIO_EV_BOTH]  = rise[3] | fall[3];
		ev[`MPIO_EV_KEY]   = |(prev_r[7:4] & ~filt_r[7:4]);
		if (!armed)
			ev = 5'h00;
		// read clears only bits already returned; a new event survives
		stat_nxt = stat_r;
		if (acc && avs_read && (avs_address == `MPIO_IRQ_STAT))
			stat_nxt = stat_r & ~rdata_r[4:0];
		stat_nxt = stat_nxt | ev;
	end

	// ****************************************
	// status and interrupt level
	// ****************************************
	always @(posedge mclk) begin
		if (rst) begin
			stat_r <= 5'h00;
			irq_r  <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq_r  <= |(stat_nxt & mask_r);
		end
	end

	// ****************************************
	// watch clock and buzzer
	// ****************************************
	// fractional accumulator, one watch tick per overflow
	wire [24:0] wsum = wacc_r + `MPIO_WT_HZ;

	always @(posedge mclk) begin
		if (rst) begin
			wacc_r <= 25'h0000000;
			wcnt_r <= 4'h0;
			buz_r  <= 1'b0;
		end else begin
			if (wsum >= `MPIO_MCLK_HZ) begin
				wacc_r <= wsum - `MPIO_MCLK_HZ;
				wcnt_r <= wcnt_r + 4'h1;
			end else begin
				wacc_r <= wsum;
			end
			case (alt_r[2:1])
			2'h0:    buz_r <= wcnt_r[3];
			2'h1:    buz_r <= wcnt_r[2];
			2'h2:    buz_r <= wcnt_r[1];
			2'h3:    buz_r <= wcnt_r[0];
			default: buz_r <= 1'b0;
			endcase
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	wire [35:0] pout_nxt;
	wire [35:0] poe_n_nxt;
	wire [35:0] ppu_nxt;

	genvar i;
	generate
		for (i = 0; i < 36; i = i + 1) begin : g_pin
			localparam P = i / 4;
			localparam B = i % 4;
			wire od  = (P == 2) | ((P == 4) & od_r[0]) | ((P == 5) & od_r[1]);
			wire ana = ((P == 2) & ana_r[B]) |
				((i == 12) & alt_r[`MPIO_ALT_AN4]) | ((i == 13) & alt_r[`MPIO_ALT_AN5]);
			wire absent = (P == 1) | (i == 35);
			wire drv = dir_r[i] & ~absent & ~ana;
			wire val = ((i == 3) & alt_r[`MPIO_ALT_BUZ_EN]) ? buz_r :
				((i == 14) & alt_r[`MPIO_ALT_CLO_EN]) ? system_clock_out :
				((i == 15) & alt_r[`MPIO_ALT_P33_EN]) ?
					(alt_r[`MPIO_ALT_P33_SRC] ? timer1_clock_out : pwm_out) :
				((i == 33) & alt_r[`MPIO_ALT_T0O_EN]) ? timer0_clock_out :
				data_r[i];
			assign pout_nxt[i]  = od ? 1'b0 : val;
			assign poe_n_nxt[i] = ~(drv & (~od | ~val));
			if (P == 1) begin : g_in
				assign ppu_nxt[i] = (B != 3) & p1pu_r[B % 3];
			end else begin : g_io
				assign ppu_nxt[i] = pu_r[P] & ~dir_r[i] & ~ana & ~absent;
			end
		end
	endgenerate

	// ****************************************
	// pin output registers
	// ****************************************
	// every pin change lands one cycle after its register
	always @(posedge mclk) begin
		if (rst) begin
			pout_r  <= 36'h000000000;
			poe_n_r <= 36'hFFFFFFFFF;
			ppu_r   <= 36'h000000000;
			t1in_r  <= 1'b0;
		end else begin
			pout_r  <= pout_nxt;
			poe_n_r <= poe_n_nxt;
			ppu_r   <= ppu_nxt;
			t1in_r  <= sync_r[14];
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign avs_readdata        = rdata_r;
	assign avs_waitrequest     = wait_r;
	assign irq                 = irq_r;
	assign pad_out             = pout_r;
	assign pad_oe_n            = poe_n_r;
	assign pad_pullup          = ppu_r;
	assign timer1_ext_clock_in = t1in_r;
	assign timer0_ext_clock_in = filt_r[8];
	assign analog_inputs       = {alt_r[`MPIO_ALT_AN5], alt_r[`MPIO_ALT_AN4], ana_r};

endmodule // mpio_top

// >>> mpio_top_sva.sv
module mpio_top_sva (
	input wire        mclk,
	input wire        rst,
	input wire        avs_read,
	input wire        avs_write,
	input wire        avs_waitrequest,
	input wire [35:0] pad_in,
	input wire [35:0] pad_out,
	input wire [35:0] pad_oe_n,
	input wire [35:0] pad_pullup,
	input wire        timer1_ext_clock_in,
	input wire [5:0]  analog_inputs
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("no answer");
	AST_PU_OUT: assert property ((pad_pullup & ~pad_oe_n) == 36'h0)
		else $error("pullup on driven pin");
	AST_IN_PORT: assert property (pad_oe_n[7:4] == 4'hF)
		else $error("input port driven");
	AST_P1_PU: assert property (!pad_pullup[7])
		else $error("pullup on fourth input pin");
	AST_OPEN_DRAIN: assert property (pad_out[11:8] == 4'h0)
		else $error("analog port drives high");
	AST_RESET: assert property ($fell(rst) |-> pad_oe_n == 36'hF_FFFF_FFFF
		&& pad_pullup == 36'h0 && analog_inputs == 6'h0F) else $error("bad reset state");
	AST_T1_SYNC: assert property ($stable(pad_in[14])[*5]
		|-> timer1_ext_clock_in == pad_in[14]) else $error("timer1 clock stale");
endmodule // mpio_top_sva

// >>> mpio_board.sv
module mpio_board (
	input  wire        mclk,
	input  wire [35:0] pad_out,
	input  wire [35:0] pad_oe_n,
	input  wire [35:0] pad_pullup,
	input  wire [35:0] ext_drv,
	input  wire [35:0] ext_en,
	output wire [35:0] pad_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic float_r = 1'b0;
	always @(posedge mclk) float_r <= ~float_r;
	// undriven unpulled pins wander every cycle
	assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_drv)
		| (pad_oe_n & ~ext_en & (pad_pullup | {36{float_r}}));
endmodule // mpio_board

// >>> tb_top.sv
`include "mpio_map.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, rst, avs_read, avs_write, sco, pwm, t1o;
	logic [7:0]  avs_address, pv;
	logic [31:0] avs_writedata, q;
	logic [35:0] ext_drv, ext_en;
	logic [3:0]  p, d, v, e, m, b;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, irq, t1i, t0i;
	wire  [35:0] pad_in, pad_out, pad_oe_n, pad_pullup;
	wire  [5:0]  analog_inputs;
	int          err_count, cmp_count, cycles, cnt;
	logic [3:0]  plist [7] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
	int          epin [8] = '{4, 5, 6, 6, 7, 7, 24, 4};
	logic [4:0]  eexp [8] = '{5'h01, 5'h02, 5'h04, 5'h00, 5'h08, 5'h08, 5'h10, 5'h00};
	logic [7:0]  elvl = 8'h15;
	mpio_top dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
		.system_clock_out(sco), .pwm_out(pwm), .timer1_clock_out(t1o),
		.timer0_clock_out(sco), .timer1_ext_clock_in(t1i), .timer0_ext_clock_in(t0i),
		.analog_inputs(analog_inputs));
	mpio_board board (.mclk(mclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
		.pad_pullup(pad_pullup), .ext_drv(ext_drv), .ext_en(ext_en), .pad_in(pad_in));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task report_and_stop;
		if (err_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 50000) begin
			err_count++;
			report_and_stop();
		end
	end
	task chk(input string n, input logic [35:0] s, input logic [35:0] x);
		cmp_count++;
		if (s !== x) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, x, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= wd;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	initial begin
		rst = 1'b1;
		{avs_read, avs_write, sco, pwm, t1o} = 5'h00;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		ext_drv = 36'h0_0F00_0020;
		ext_en = 36'hF_FFFF_F0FF;
		q = $urandom(94);
		cyc(2);
		rst <= 1'b0;
		for (int k = 0; k < 9; k++) begin
			bus(0, `MPIO_DIR_BASE + 8'(4 * k), 0);
			chk("dir_rst", q, 0);
		end
		bus(0, `MPIO_ANALOG, 0);
		chk("an_rst", q, 4'hF);
		bus(0, `MPIO_IRQ_STAT, 0);
		chk("stat_rst", q, 0);
		bus(0, 8'hFC, 0);
		chk("unmapped", q, 0);
		bus(1, `MPIO_DIR_BASE + 8'h04, 4'hF);
		bus(0, `MPIO_DIR_BASE + 8'h04, 0);
		chk("in_dir", q, 0);
		bus(1, `MPIO_P1_PULLUP, 4'hF);
		bus(1, `MPIO_PULLUP, 32'h1FF);
		cyc(3);
		chk("p1_pu", pad_pullup[7:4], 4'h7);
		for (int i = 0; i < 7; i++) begin
			p = plist[i];
			m = (p == 4'h8) ? 4'h7 : 4'hF;
			{d, v, e, b} = 16'($urandom);
			ext_drv[4*p+:4] <= e;
			bus(1, `MPIO_DIR_BASE + {p, 2'h0}, d);
			bus(1, `MPIO_DATA_BASE + {p, 2'h0}, v);
			bus(1, `MPIO_BITOP, {b[2], b[1:0], p});
			v[b[1:0]] = b[2];
			cyc(4);
			bus(0, `MPIO_DIR_BASE + {p, 2'h0}, 0);
			chk("dir", q, d & m);
			chk("oe_n", pad_oe_n[4*p+:4], 4'(~(d & m)));
			chk("pullup", pad_pullup[4*p+:4], ~d & m);
			bus(0, `MPIO_DATA_BASE + {p, 2'h0}, 0);
			chk("data", q & m, (v & d | e & ~d) & m);
		end
		bus(1, `MPIO_ANALOG, 0);
		bus(1, `MPIO_DIR_BASE + 8'h08, 4'hF);
		bus(1, `MPIO_DATA_BASE + 8'h08, 4'h3);
		bus(1, `MPIO_DRIVE, 1);
		bus(1, `MPIO_DIR_BASE + 8'h10, 4'hF);
		bus(1, `MPIO_DIR_BASE + 8'h14, 4'hF);
		pv = 8'($urandom);
		bus(1, `MPIO_PAIR, pv);
		cyc(3);
		chk("an_pin", analog_inputs, 0);
		chk("od_p2", pad_oe_n[11:8], 4'h3);
		chk("od_p4", pad_oe_n[19:16], pv[3:0]);
		chk("pp_p5", pad_oe_n[23:20], 0);
		bus(0, `MPIO_DATA_BASE + 8'h14, 0);
		chk("pair_hi", q, pv[7:4]);
		bus(0, `MPIO_PAIR, 0);
		chk("pair", q, pv);
		bus(1, `MPIO_DIR_BASE + 8'h0C, 4'hC);
		for (int k = 0; k < 4; k++) begin
			sco <= k[0];
			pwm <= k[0];
			t1o <= !k[0];
			bus(1, `MPIO_ALT, 32'h18 | k[1] << 5);
			cyc(5);
			chk("t1_in", t1i, k[0]);
			chk("clk_out", pad_out[14], k[0]);
			chk("p33", pad_out[15], k[0] ^ k[1]);
		end
		bus(1, `MPIO_DIR_BASE + 8'h18, 0);
		bus(1, `MPIO_DIR_BASE + 8'h20, 0);
		ext_drv[27:24] <= 4'hF;
		ext_drv[32] <= 1'b0;
		cyc(12);
		chk("t0_lo", t0i, 0);
		bus(0, `MPIO_IRQ_STAT, 0);
		bus(1, `MPIO_IRQ_MASK, 32'h1F);
		bus(1, `MPIO_EDGE, 1);
		for (int k = 0; k < 8; k++) begin
			ext_drv[epin[k]] <= elvl[k];
			cyc(12);
			chk("irq", irq, eexp[k] != 0);
			bus(0, `MPIO_IRQ_STAT, 0);
			chk("stat", q, eexp[k]);
			cyc(2);
			chk("irq_clr", irq, 0);
		end
		bus(1, `MPIO_IRQ_MASK, 0);
		ext_drv[7] <= 1'b1;
		ext_drv[32] <= 1'b1;
		cyc(2);
		ext_drv[6] <= 1'b1;
		cyc(2);
		ext_drv[6] <= 1'b0;
		cyc(12);
		chk("irq_mask", irq, 0);
		chk("t0_in", t0i, 1);
		bus(0, `MPIO_IRQ_STAT, 0);
		chk("glitch", q, 5'h08);
		bus(1, `MPIO_DIR_BASE, 4'h8);
		for (int f = 0; f < 4; f++) begin
			bus(1, `MPIO_ALT, 1 | f << 1);
			cnt = 0;
			repeat (10000) begin
				b[0] = pad_out[3];
				@(posedge mclk);
				if (pad_out[3] && !b[0])
					cnt++;
			end
			chk("buzz", cnt >= (2 << f) && cnt <= (2 << f) + 1, 1);
		end
		report_and_stop();
	end
endmodule // tb_top
bind mpio_top mpio_top_sva u_sva (.mclk(mclk), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .pad_in(pad_in),
	.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
	.timer1_ext_clock_in(timer1_ext_clock_in), .analog_inputs(analog_inputs));
